// [hdl/bql_mem.sv]
`timescale 1ns/1ps
module bql_mem #(
	parameter int DW = 33,
	parameter int AW = 10
) (
	input wire logic pclk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [2**AW];

	// no reset on the array: contents are loaded before use
	always_ff @(posedge pclk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// [hdl/bql_pkg.sv]
package bql_pkg;
	// ==========================================================
	// queue layout
	localparam int NQ = 4;
	localparam int NEND = 6;
	localparam int BYTES_PER_WORD = 4;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] A_MODE = 8'h00;
	localparam logic [7:0] A_END0 = 8'h04;
	localparam logic [7:0] A_CLAIM = 8'h1C;
	localparam logic [7:0] A_BEACON = 8'h20;
	localparam logic [7:0] A_SFRP = 8'h24;
	localparam logic [7:0] A_WP0 = 8'h30;
	localparam logic [7:0] A_RP0 = 8'h40;
	localparam logic [7:0] A_SWP0 = 8'h50;
	localparam logic [7:0] A_STATUS = 8'h60;
	// ==========================================================
	// mode register fields
	localparam int MODE_TAG = 0;
	localparam int MODE_LSB = 1;
	localparam int MODE_OP_LO = 2;
	localparam int MODE_AF_LO = 4;
	localparam logic [3:0] AF_RST = 4'h0;
	// ==========================================================
	// status register fields
	localparam int ST_FULL_LO = 0;
	localparam int ST_UNDER_LO = 4;
	localparam int ST_OP_LO = 8;
	// ==========================================================
	// queue-control codes
	localparam logic [2:0] QC_ROOM = 3'h0;
	localparam logic [2:0] QC_ALMOST = 3'h1;
	localparam logic [2:0] QC_ABORT = 3'h2;
	typedef enum logic [1:0] {OP_INIT, OP_MEMACT, OP_ONLINE, OP_RSVD} bql_op_e;
endpackage

// [hdl/bql_qptr.sv]
`timescale 1ns/1ps
module bql_qptr #(
	parameter int AW = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [AW-1:0] q_start,
	input wire logic [AW-1:0] q_end,
	input wire logic wp_load,
	input wire logic rp_load,
	input wire logic [AW-1:0] load_val,
	input wire logic push,
	input wire logic push_desc,
	input wire logic pop,
	output logic [AW-1:0] wp,
	output logic [AW-1:0] rp,
	output logic [AW-1:0] swp,
	output logic [AW-1:0] free_words,
	output logic full
);
	logic [AW-1:0] size;
	logic [AW-1:0] used;
	logic [AW-1:0] wp_next;

	// an ignored queue has end equal to the previous end: size wraps to 0
	assign size = q_end - q_start + AW'(1);
	assign used = (wp >= rp) ? wp - rp : wp + size - rp;
	assign free_words = size - AW'(1) - used;
	assign full = (size == '0) || (free_words == '0);
	assign wp_next = (wp == q_end) ? q_start : wp + AW'(1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wp <= '0;
			swp <= '0;
		end
		else if (wp_load)
		begin
			wp <= load_val;
			swp <= load_val;
		end
		else if (push)
		begin
			wp <= wp_next;
			// descriptor closes the frame: shadow marks next frame start
			if (push_desc)
			begin
				swp <= wp_next;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rp <= '0;
		end
		else if (rp_load)
		begin
			rp <= load_val;
		end
		else if (pop && rp != swp)
		begin
			rp <= (rp == q_end) ? q_start : rp + AW'(1);
		end
	end
endmodule

// [hdl/bql_top.sv]
`timescale 1ns/1ps
module bql_top
	import bql_pkg::*;
#(
	parameter int AW = 16,
	parameter int MAW = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic host_req,
	input wire logic [1:0] host_queue,
	input wire logic [31:0] host_data,
	input wire logic host_tag,
	output logic host_ack,
	output logic [2:0] queue_control_code,
	input wire logic [NQ-1:0] tx_pop,
	input wire logic [NQ-1:0] tx_underrun,
	input wire logic [MAW-1:0] tx_rd_addr,
	output logic [31:0] tx_rd_data,
	output logic tx_rd_tag,
	input wire logic claim_enter,
	input wire logic beacon_enter,
	output logic [AW-1:0] special_frame_read_ptr,
	input wire logic rx_frame_start,
	output logic rx_accept,
	input wire logic ser_load,
	input wire logic [31:0] ser_word,
	input wire logic ser_ctrl,
	output logic [7:0] ser_byte,
	output logic ser_valid
);
	// ==========================================================
	// elaboration checks
	if (MAW > AW || AW > 32)
	begin : g_bad_width
		$error("bql_top: need MAW <= AW <= 32");
	end
	if (QC_ALMOST == QC_ABORT || QC_ALMOST == 3'h0 || QC_ABORT == 3'h0)
	begin : g_bad_code
		$error("bql_top: queue-control codes must differ and be nonzero");
	end

	// ==========================================================
	// state
	logic tag_mode_reg;
	logic lsb_first_reg;
	bql_op_e op_mode_reg;
	logic [3:0] almost_full_setting_reg;
	logic [AW-1:0] end_reg [NEND];
	logic [AW-1:0] claim_frame_start_ptr_reg;
	logic [AW-1:0] beacon_frame_start_ptr_reg;
	logic [NQ-1:0] full_flag_reg;
	logic [NQ-1:0] under_flag_reg;
	logic [NQ-1:0] last_tag_reg;
	logic [31:0] ser_shift_reg;
	logic [1:0] ser_left_reg;
	logic ser_lsb_reg;

	logic wr_en;
	logic rd_en;
	logic [31:0] rd_data;
	logic addr_ok;
	logic [AW-1:0] wp_w [NQ];
	logic [AW-1:0] rp_w [NQ];
	logic [AW-1:0] swp_w [NQ];
	logic [AW-1:0] free_w [NQ];
	logic [NQ-1:0] full_w;
	logic [NQ-1:0] wp_load;
	logic [NQ-1:0] rp_load;
	logic [NQ-1:0] push;
	logic [NQ-1:0] set_full;
	logic [NQ-1:0] clr_full;
	logic [NQ-1:0] clr_under;
	logic req_ok;
	logic sel_under;
	logic sel_full;
	logic accept;
	logic is_desc;
	logic almost;
	logic order_lsb;

	// ==========================================================
	// apb slave: one wait state, answer registered
	assign wr_en = psel && penable && pwrite && !pready;
	assign rd_en = psel && penable && !pwrite && !pready;

	always_comb
	begin
		rd_data = '0;
		addr_ok = 1'b1;
		wp_load = '0;
		rp_load = '0;
		if (paddr == A_MODE)
		begin
			rd_data[MODE_TAG] = tag_mode_reg;
			rd_data[MODE_LSB] = lsb_first_reg;
			rd_data[MODE_OP_LO +: 2] = op_mode_reg;
			rd_data[MODE_AF_LO +: 4] = almost_full_setting_reg;
		end
		else if (paddr == A_CLAIM)
			rd_data[AW-1:0] = claim_frame_start_ptr_reg;
		else if (paddr == A_BEACON)
			rd_data[AW-1:0] = beacon_frame_start_ptr_reg;
		else if (paddr == A_SFRP)
			rd_data[AW-1:0] = special_frame_read_ptr;
		else if (paddr == A_STATUS)
		begin
			rd_data[ST_FULL_LO +: NQ] = full_flag_reg;
			rd_data[ST_UNDER_LO +: NQ] = under_flag_reg;
			rd_data[ST_OP_LO +: 2] = op_mode_reg;
		end
		else
		begin
			addr_ok = 1'b0;
			for (int i = 0; i < NEND; i++)
			begin
				if (paddr == A_END0 + 8'(i * 4))
				begin
					rd_data[AW-1:0] = end_reg[i];
					addr_ok = 1'b1;
				end
			end
			for (int q = 0; q < NQ; q++)
			begin
				if (paddr == A_WP0 + 8'(q * 4))
				begin
					rd_data[AW-1:0] = wp_w[q];
					wp_load[q] = wr_en;
					addr_ok = 1'b1;
				end
				if (paddr == A_RP0 + 8'(q * 4))
				begin
					rd_data[AW-1:0] = rp_w[q];
					rp_load[q] = wr_en;
					addr_ok = 1'b1;
				end
				if (paddr == A_SWP0 + 8'(q * 4))
				begin
					rd_data[AW-1:0] = swp_w[q];
					addr_ok = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
			if (rd_en)
			begin
				prdata <= addr_ok ? rd_data : '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tag_mode_reg <= 1'b0;
			lsb_first_reg <= 1'b0;
			op_mode_reg <= OP_INIT;
			almost_full_setting_reg <= AF_RST;
			claim_frame_start_ptr_reg <= '0;
			beacon_frame_start_ptr_reg <= '0;
			for (int i = 0; i < NEND; i++)
			begin
				end_reg[i] <= '0;
			end
		end
		else if (wr_en)
		begin
			if (paddr == A_MODE)
			begin
				tag_mode_reg <= pwdata[MODE_TAG];
				lsb_first_reg <= pwdata[MODE_LSB];
				op_mode_reg <= bql_op_e'(pwdata[MODE_OP_LO +: 2]);
				almost_full_setting_reg <= pwdata[MODE_AF_LO +: 4];
			end
			if (paddr == A_CLAIM)
				claim_frame_start_ptr_reg <= pwdata[AW-1:0];
			if (paddr == A_BEACON)
				beacon_frame_start_ptr_reg <= pwdata[AW-1:0];
			for (int i = 0; i < NEND; i++)
			begin
				if (paddr == A_END0 + 8'(i * 4))
					end_reg[i] <= pwdata[AW-1:0];
			end
		end
	end

	// ==========================================================
	// transmit queues, tag-mode order after the receive queue
	for (genvar q = 0; q < NQ; q++)
	begin : g_q
		bql_qptr #(.AW(AW)) u_qptr (
			.pclk(pclk),
			.presetn(presetn),
			.q_start(end_reg[q + 1] + AW'(1)),
			.q_end(end_reg[q + 2]),
			.wp_load(wp_load[q]),
			.rp_load(rp_load[q]),
			.load_val(pwdata[AW-1:0]),
			.push(push[q]),
			.push_desc(is_desc),
			.pop(tx_pop[q]),
			.wp(wp_w[q]),
			.rp(rp_w[q]),
			.swp(swp_w[q]),
			.free_words(free_w[q]),
			.full(full_w[q])
		);
	end

	// ==========================================================
	// host write requests (tag mode only)
	assign req_ok = host_req && tag_mode_reg;
	assign sel_under = under_flag_reg[host_queue];
	assign sel_full = full_w[host_queue];
	// underrun outranks full so the host learns to drop the frame
	assign accept = req_ok && !sel_under && !sel_full;
	assign is_desc = host_tag && last_tag_reg[host_queue];
	assign almost = free_w[host_queue] == AW'({almost_full_setting_reg, 1'b0});

	always_comb
	begin
		push = '0;
		set_full = '0;
		push[host_queue] = accept;
		set_full[host_queue] = req_ok && sel_full && !sel_under;
	end

	bql_mem #(.DW(33), .AW(MAW)) u_mem (
		.pclk(pclk),
		.wr_en(accept),
		.wr_addr(wp_w[host_queue][MAW-1:0]),
		.wr_data({host_tag, host_data}),
		.rd_addr(tx_rd_addr),
		.rd_data({tx_rd_tag, tx_rd_data})
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			host_ack <= 1'b0;
			queue_control_code <= QC_ROOM;
		end
		else
		begin
			host_ack <= accept;
			if (req_ok)
			begin
				if (sel_under)
					queue_control_code <= QC_ABORT;
				else if (accept && almost)
					queue_control_code <= QC_ALMOST;
				else
					queue_control_code <= QC_ROOM;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_tag_reg <= '0;
		else
		begin
			for (int q = 0; q < NQ; q++)
			begin
				if (push[q])
					last_tag_reg[q] <= host_tag && !last_tag_reg[q];
			end
		end
	end

	// ==========================================================
	// sticky status, write one to clear, a new event wins
	assign clr_full = (wr_en && paddr == A_STATUS) ?
		pwdata[ST_FULL_LO +: NQ] : '0;
	assign clr_under = (wr_en && paddr == A_STATUS) ?
		pwdata[ST_UNDER_LO +: NQ] : '0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			full_flag_reg <= '0;
			under_flag_reg <= '0;
		end
		else
		begin
			full_flag_reg <= (full_flag_reg & ~clr_full) | set_full;
			under_flag_reg <= (under_flag_reg & ~clr_under) | tx_underrun;
		end
	end

	// ==========================================================
	// recovery entry and receive gating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			special_frame_read_ptr <= '0;
			rx_accept <= 1'b0;
		end
		else
		begin
			rx_accept <= rx_frame_start && op_mode_reg == OP_ONLINE;
			if (op_mode_reg != OP_MEMACT)
			begin
				if (beacon_enter)
					special_frame_read_ptr <= beacon_frame_start_ptr_reg;
				else if (claim_enter)
					special_frame_read_ptr <= claim_frame_start_ptr_reg;
			end
		end
	end

	// ==========================================================
	// word to byte serialiser
	// control words keep msb first
	assign order_lsb = !tag_mode_reg && lsb_first_reg && !ser_ctrl;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ser_shift_reg <= '0;
			ser_left_reg <= '0;
			ser_lsb_reg <= 1'b0;
			ser_byte <= '0;
			ser_valid <= 1'b0;
		end
		else if (ser_load)
		begin
			ser_lsb_reg <= order_lsb;
			ser_byte <= order_lsb ? ser_word[7:0] : ser_word[31:24];
			ser_shift_reg <= order_lsb ? {8'h00, ser_word[31:8]} :
				{ser_word[23:0], 8'h00};
			ser_left_reg <= 2'(BYTES_PER_WORD - 1);
			ser_valid <= 1'b1;
		end
		else if (ser_left_reg != '0)
		begin
			ser_byte <= ser_lsb_reg ? ser_shift_reg[7:0] :
				ser_shift_reg[31:24];
			ser_shift_reg <= ser_lsb_reg ? {8'h00, ser_shift_reg[31:8]} :
				{ser_shift_reg[23:0], 8'h00};
			ser_left_reg <= ser_left_reg - 2'h1;
			ser_valid <= 1'b1;
		end
		else
			ser_valid <= 1'b0;
	end

	// ==========================================================
	// checks
	full_noack_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		req_ok && sel_full && !sel_under |=> !host_ack &&
		queue_control_code == QC_ROOM && full_flag_reg[$past(host_queue)])
		else $error("full queue was acknowledged");
	abort_code_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		req_ok && sel_under |=> queue_control_code == QC_ABORT && !host_ack)
		else $error("underrun queue missed abort code");
	ack_room_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		accept && !almost |=> host_ack && queue_control_code == QC_ROOM)
		else $error("room request not acknowledged");
	almost_code_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		accept && almost |=> host_ack && queue_control_code == QC_ALMOST)
		else $error("almost-full code missing");
	wp_step_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		accept && !wp_load[host_queue] |=>
		wp_w[$past(host_queue)] != $past(wp_w[host_queue]))
		else $error("write pointer did not advance");
	shadow_copy_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		accept && is_desc && !wp_load[host_queue] |=>
		swp_w[$past(host_queue)] == wp_w[$past(host_queue)])
		else $error("shadow pointer not loaded on descriptor");
	memact_rx_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		op_mode_reg == OP_MEMACT |=> !rx_accept)
		else $error("frame accepted in memory-active mode");
	sfrp_claim_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		claim_enter && !beacon_enter && op_mode_reg != OP_MEMACT |=>
		special_frame_read_ptr == $past(claim_frame_start_ptr_reg))
		else $error("special read pointer not loaded on claim");
	sfrp_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		op_mode_reg == OP_MEMACT |=> $stable(special_frame_read_ptr))
		else $error("recovery reacted in memory-active mode");
	byte_lsb_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		ser_load && order_lsb |=> ser_byte == $past(ser_word[7:0]))
		else $error("least significant byte not first");
	ctrl_msb_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		ser_load && ser_ctrl |=> ser_byte == $past(ser_word[31:24]))
		else $error("control word byte order changed");
endmodule

// [tb/bql_host_model.sv]
`timescale 1ns/1ps
// ==========================================================
// host dma model: one transmit frame per start pulse
module bql_host_model import bql_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [1:0] queue,
	input wire logic [3:0] ndata,
	input wire logic [31:0] base,
	input wire logic slow,
	input wire logic [2:0] queue_control_code,
	output logic host_req,
	output logic [1:0] host_queue,
	output logic [31:0] host_data,
	output logic host_tag,
	output logic busy
);
	logic [3:0] idx;
	logic pend;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy <= 1'b0;
			host_req <= 1'b0;
			host_queue <= 2'h0;
			host_data <= 32'h0;
			host_tag <= 1'b0;
			idx <= 4'h0;
			pend <= 1'b0;
		end
		else
		begin
			pend <= host_req;
			if (!busy || idx > ndata)
			begin
				// released lines toggle so stale data never looks valid
				host_req <= 1'b0;
				host_data <= ~host_data;
				host_tag <= ~host_tag;
				busy <= start;
				idx <= 4'h0;
				host_queue <= queue;
			end
			else if (pend && queue_control_code === QC_ABORT)
			begin
				busy <= 1'b0;
				host_req <= 1'b0;
			end
			else if (slow && host_req)
				host_req <= 1'b0;
			else
			begin
				host_req <= 1'b1;
				host_data <= base + 32'(idx);
				host_tag <= (idx + 4'h1 >= ndata);
				idx <= idx + 4'h1;
			end
		end
	end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench import bql_pkg::*; ();
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, ser_load = 1'b0, ser_ctrl = 1'b0, errv;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, ser_word = 32'h0, prdata, rdv, w;
	logic pready, pslverr, host_req, host_tag, host_ack, tx_rd_tag;
	logic rx_accept, ser_valid, m_busy, m_start = 1'b0, m_slow = 1'b0;
	logic claim_enter = 1'b0, beacon_enter = 1'b0, rx_frame_start = 1'b0;
	logic [1:0] host_queue, m_q = 2'h0;
	logic [31:0] host_data, tx_rd_data, m_base = 32'h0;
	logic [2:0] queue_control_code, cs;
	logic [3:0] tx_underrun = 4'h0, m_n = 4'h1, e;
	logic [9:0] tx_rd_addr = 10'h0;
	logic [15:0] special_frame_read_ptr;
	logic [7:0] ser_byte;
	logic tagm = 1'b0, req_d = 1'b0;
	logic [3:0] expq [$];
	int fails = 0, check_count = 0, cyc = 0;
	logic [31:0] ends [6] = '{32'h0F, 32'h1F, 32'h27, 32'h2F, 32'h2F, 32'h37};
	logic [31:0] qs [4] = '{32'h20, 32'h28, 32'h30, 32'h30};
	logic [2:0] cases [4] = '{3'b010, 3'b000, 3'b011, 3'b110};

	bql_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .host_req, .host_queue,
		.host_data, .host_tag, .host_ack, .queue_control_code,
		.tx_pop(4'h0), .tx_underrun, .tx_rd_addr, .tx_rd_data, .tx_rd_tag,
		.claim_enter, .beacon_enter, .special_frame_read_ptr,
		.rx_frame_start, .rx_accept, .ser_load, .ser_word, .ser_ctrl,
		.ser_byte, .ser_valid);
	bql_host_model host (.pclk, .presetn, .start(m_start), .queue(m_q),
		.ndata(m_n), .base(m_base), .slow(m_slow), .queue_control_code,
		.host_req, .host_queue, .host_data, .host_tag, .busy(m_busy));

	always #4 pclk = ~pclk;

	// ==========================================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the bench timeout ends this wait
		while (pready !== 1'b1)
			@(posedge pclk);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next call never re-drives psel in this step
		@(posedge pclk);
	endtask

	task automatic note(input logic a, input logic [2:0] c, input int n);
		repeat (n) expq.push_back({a, c});
	endtask

	task automatic frame(input logic [1:0] q, input logic [3:0] n,
		input logic s);
		m_q <= q;
		m_n <= n;
		m_slow <= s;
		m_base <= $urandom;
		m_start <= 1'b1;
		@(posedge pclk);
		m_start <= 1'b0;
		@(posedge pclk);
		while (m_busy === 1'b1)
			@(posedge pclk);
		repeat (3) @(posedge pclk);
		check("replies left", 32'(expq.size()), 32'h0);
	endtask

	task automatic pulse(input logic c, input logic b);
		claim_enter <= c;
		beacon_enter <= b;
		rx_frame_start <= 1'b1;
		@(posedge pclk);
		claim_enter <= 1'b0;
		beacon_enter <= 1'b0;
		rx_frame_start <= 1'b0;
		@(posedge pclk);
	endtask

	// ==========================================================
	// host reply monitor and timeout
	always @(posedge pclk)
	begin
		if (req_d)
		begin
			e = (expq.size() > 0) ? expq.pop_front() : 4'hF;
			check("host ack", {31'h0, host_ack}, {31'h0, e[3]});
			check("qctl", {29'h0, queue_control_code}, {29'h0, e[2:0]});
		end
		req_d <= host_req & tagm;
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			fails++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(32'h967474c4));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, A_MODE, 32'h0);
		check("mode reset", rdv, 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		check("unmapped", {31'h0, errv}, 32'h1);
		for (int i = 0; i < NEND; i++)
			apb(1'b1, A_END0 + 8'(4 * i), ends[i]);
		for (int q = 0; q < NQ; q++)
		begin
			apb(1'b1, A_WP0 + 8'(4 * q), qs[q]);
			apb(1'b1, A_RP0 + 8'(4 * q), qs[q]);
		end
		apb(1'b1, A_MODE, 32'h21);
		tagm <= 1'b1;
		$display("test setup done");
		// four words, the last finds free words equal to twice the setting
		note(1'b1, QC_ROOM, 3);
		note(1'b1, QC_ALMOST, 1);
		frame(2'd0, 4'd3, 1'b0);
		apb(1'b0, A_WP0, 32'h0);
		check("wp sync", rdv, 32'h24);
		apb(1'b0, A_SWP0, 32'h0);
		check("shadow wp", rdv, 32'h24);
		for (int k = 0; k < 4; k++)
		begin
			tx_rd_addr <= 10'h20 + 10'(k);
			repeat (2) @(posedge pclk);
			check("mem data", tx_rd_data, m_base + 32'(k));
			check("mem tag", {31'h0, tx_rd_tag}, 32'(k >= 2));
		end
		$display("test frame done");
		note(1'b1, QC_ROOM, 3);
		note(1'b0, QC_ROOM, 2);
		frame(2'd0, 4'd4, 1'b1);
		apb(1'b0, A_WP0, 32'h0);
		check("wp full", rdv, 32'h27);
		apb(1'b0, A_STATUS, 32'h0);
		check("full flag", rdv, 32'h1);
		apb(1'b1, A_STATUS, 32'hF);
		$display("test full done");
		tx_underrun <= 4'h2;
		@(posedge pclk);
		tx_underrun <= 4'h0;
		note(1'b0, QC_ABORT, 1);
		frame(2'd1, 4'd2, 1'b1);
		apb(1'b0, A_WP0 + 8'h4, 32'h0);
		check("wp underrun", rdv, 32'h28);
		note(1'b1, QC_ROOM, 2);
		frame(2'd3, 4'd1, 1'b0);
		note(1'b0, QC_ROOM, 2);
		frame(2'd2, 4'd1, 1'b0);
		apb(1'b0, A_STATUS, 32'h0);
		check("status", rdv, 32'h24);
		$display("test underrun done");
		apb(1'b1, A_CLAIM, 32'h5);
		apb(1'b1, A_MODE, 32'h25);
		pulse(1'b1, 1'b0);
		check("memact ptr", {16'h0, special_frame_read_ptr}, 32'h0);
		check("memact rx", {31'h0, rx_accept}, 32'h0);
		apb(1'b1, A_MODE, 32'h29);
		apb(1'b1, A_BEACON, 32'hA);
		pulse(1'b1, 1'b0);
		check("claim ptr", {16'h0, special_frame_read_ptr}, 32'h5);
		check("online rx", {31'h0, rx_accept}, 32'h1);
		pulse(1'b0, 1'b1);
		check("beacon ptr", {16'h0, special_frame_read_ptr}, 32'hA);
		$display("test recovery done");
		for (int c = 0; c < 4; c++)
		begin
			cs = cases[c];
			apb(1'b1, A_MODE, {28'h0, 2'b10, cs[1], cs[2]});
			tagm <= cs[2];
			w = $urandom;
			ser_word <= w;
			ser_ctrl <= cs[0];
			ser_load <= 1'b1;
			@(posedge pclk);
			ser_load <= 1'b0;
			for (int k = 0; k < 4; k++)
			begin
				@(posedge pclk);
				check("ser valid", {31'h0, ser_valid}, 32'h1);
				check("ser byte", {24'h0, ser_byte}, {24'h0,
					(cs == 3'b010) ? w[8 * k +: 8] : w[24 - 8 * k +: 8]});
			end
		end
		$display("test byte order done");
		tally_and_finish();
	end
endmodule
